/* File: pkg/prc_pkg.sv */
// Purpose: Constants and types of the pixel readback pack converter.
// Assumes: AXI4-Lite register window with byte addresses.
// Notes:   Floats are single precision words throughout.
package prc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DEST = 8'h04;
  localparam logic [7:0] OFF_BIND = 8'h08;
  localparam logic [7:0] OFF_BSZ  = 8'h0c;
  localparam logic [7:0] OFF_SIZE = 8'h10;
  localparam logic [7:0] OFF_ROW  = 8'h14;
  localparam logic [7:0] OFF_SKIP = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1c;
  localparam logic [7:0] OFF_MASK = 8'h20;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTL_CLAMP_LSB = 0;
  localparam int CTL_REV_BIT   = 2;
  localparam int CTL_GO_BIT    = 3;
  localparam int CTL_TYPE_LSB  = 4;
  localparam int CTL_FMT_LSB   = 9;
  localparam int ROW_ALIGN_LSB = 16;
  localparam int ST_DONE       = 0;
  localparam int ST_ERR        = 1;
  localparam int ST_BUSY       = 2;
  localparam logic [3:0] ALIGN_RST = 4'h4;
  localparam logic [31:0] F_ONE    = 32'h3f80_0000;
  localparam logic [31:0] F_SE_MAX = 32'h477f_8000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    CLAMP_FALSE = 2'b00, CLAMP_TRUE = 2'b01, CLAMP_FIXED_ONLY = 2'b10
  } prc_clamp_t;
  localparam prc_clamp_t CLAMP_RST = CLAMP_FIXED_ONLY;
  typedef enum logic [4:0] {
    T_UBYTE = 5'd0, T_BYTE = 5'd1, T_USHORT = 5'd2, T_SHORT = 5'd3,
    T_UINT = 5'd4, T_INT = 5'd5, T_HALF = 5'd6, T_FLOAT = 5'd7,
    T_P332 = 5'd8, T_P565 = 5'd9, T_P4444 = 5'd10, T_P5551 = 5'd11,
    T_P8888 = 5'd12, T_P1010102 = 5'd13, T_P248 = 5'd14,
    T_SMALL_FLOAT_RGB = 5'd15, T_SHARED_EXP_RGB = 5'd16, T_FDS = 5'd17
  } prc_type_t;
  typedef enum logic [3:0] {
    F_RED = 4'd0, F_GREEN = 4'd1, F_BLUE = 4'd2, F_ALPHA = 4'd3, F_RG = 4'd4,
    F_RGB = 4'd5, F_BGR = 4'd6, F_RGBA = 4'd7, F_BGRA = 4'd8, F_DEPTH = 4'd9,
    F_STENCIL = 4'd10, F_DS = 4'd11
  } prc_fmt_t;
  typedef enum logic [2:0] {
    K_FIXED = 3'd0, K_FLOAT = 3'd1, K_SINT = 3'd2, K_UINT = 3'd3,
    K_INDEX = 3'd4, K_DS = 3'd5
  } prc_kind_t;
  typedef enum logic {S_IDLE = 1'b0, S_RUN = 1'b1} prc_state_t;
endpackage

/* File: rtl/prc_converter.sv */
// Purpose: Final conversion and placement of read-back pixel groups.
// Assumes: Upstream delivers float, integer or index components per group.
// Notes:   One memory word per element, or one per packed group.
`timescale 1ns/1ps
module prc_converter
  import prc_pkg::*;
#(
  parameter int DIM_W = 16
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire logic [2:0]  pix_kind,
  input  wire logic [31:0] pix_c0,
  input  wire logic [31:0] pix_c1,
  input  wire logic [31:0] pix_c2,
  input  wire logic [31:0] pix_c3,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_data,
  output logic [2:0]       mem_size,
  output logic             mem_to_buffer,
  output logic             irq
);
  if (DIM_W < 1 || DIM_W > 16) begin : g_chk
    $error("DIM_W must lie in 1..16");
  end
  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function automatic logic [31:0] be(input logic [31:0] o, input logic [31:0] n,
                                     input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      o[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
    end
    return o;
  endfunction
  function automatic logic [31:0] msk(input logic [5:0] w);
    return 32'((64'h1 << w) - 64'h1);
  endfunction
  function automatic logic [31:0] cl01(input logic [31:0] f);
    if (f[31] || (f[30:23] == 8'hff && f[22:0] != 23'h0)) return 32'h0;
    return (f[30:0] >= F_ONE[30:0]) ? F_ONE : f;
  endfunction
  // Float in [0,1] to 1.32 fixed point
  function automatic logic [32:0] f2fx(input logic [31:0] f);
    logic [63:0] m;
    m = {40'h0, 1'b1, f[22:0]} << 8;
    if (f[30:23] >= 8'd127) return 33'h1_0000_0000;
    if (f[30:23] < 8'd96) return 33'h0;
    m = m >> (8'd126 - f[30:23]);
    return m[32:0];
  endfunction
  // Magnitude to 5-bit exponent, 10-bit mantissa; small-float callers truncate it, half callers keep it whole
  function automatic logic [14:0] minif(input logic [31:0] f);
    logic [7:0]  e;
    logic [23:0] m;
    e = f[30:23];
    m = {1'b1, f[22:0]};
    if (e == 8'hff) return {5'h1f, (f[22:0] != 23'h0), 9'h0};
    if (e >= 8'd143) return {5'h1f, 10'h0};
    if (e >= 8'd113) return {5'(e - 8'd112), f[22:13]};
    if (e == 8'd0) return 15'h0;
    m = m >> (8'd126 - e);
    return {5'h0, m[9:0]};
  endfunction
  function automatic logic [31:0] i2f(input logic [31:0] v);
    int          p;
    logic [31:0] sh;
    p = 0;
    for (int b = 0; b < 32; b++) begin
      if (v[b]) p = b;
    end
    sh = v << (31 - p);
    return (v == 32'h0) ? 32'h0 : {1'b0, 8'(127 + p), sh[30:8]};
  endfunction
  function automatic logic [9:0] m9(input logic [31:0] f, input logic [4:0] es);
    int          sh;
    logic [63:0] t;
    sh = int'(es) + 126 - int'(f[30:23]);
    if (f[30:23] == 8'h0 || sh > 40 || sh < 1) return 10'h0;
    t = ({40'h0, 1'b1, f[22:0]} + (64'h1 << (sh - 1))) >> sh;
    return t[9:0];
  endfunction
  function automatic logic [31:0] sat(input logic [31:0] v, input logic [5:0] w,
                                      input logic ss, input logic sd);
    logic signed [33:0] x;
    logic signed [33:0] hi;
    logic signed [33:0] lo;
    x  = ss ? 34'(signed'(v)) : {2'b00, v};
    hi = sd ? (34'sd1 <<< (w - 6'd1)) - 34'sd1 : (34'sd1 <<< w) - 34'sd1;
    lo = sd ? -(34'sd1 <<< (w - 6'd1)) : 34'sd0;
    if (x > hi) return hi[31:0];
    if (x < lo) return lo[31:0];
    return x[31:0];
  endfunction
  function automatic logic [23:0] fwtab(input logic [4:0] t);
    unique case (t)
      T_P332:            return {6'd0, 6'd2, 6'd3, 6'd3};
      T_P565:            return {6'd0, 6'd5, 6'd6, 6'd5};
      T_P4444:           return {6'd4, 6'd4, 6'd4, 6'd4};
      T_P5551:           return {6'd1, 6'd5, 6'd5, 6'd5};
      T_P8888:           return {6'd8, 6'd8, 6'd8, 6'd8};
      T_P1010102:        return {6'd2, 6'd10, 6'd10, 6'd10};
      T_P248:            return {6'd0, 6'd0, 6'd8, 6'd24};
      T_SMALL_FLOAT_RGB: return {6'd0, 6'd10, 6'd11, 6'd11};
      T_SHARED_EXP_RGB:  return {6'd5, 6'd9, 6'd9, 6'd9};
      default:           return 24'h0;
    endcase
  endfunction
  function automatic logic [5:0] twid(input logic [4:0] t);
    unique case (t)
      T_UBYTE, T_BYTE, T_P332:                        return 6'd8;
      T_USHORT, T_SHORT, T_HALF, T_P565, T_P4444, T_P5551: return 6'd16;
      default: return (t <= T_FDS) ? 6'd32 : 6'd0;
    endcase
  endfunction
  function automatic logic [5:0] psum(input logic [23:0] v, input int k);
    logic [5:0] s;
    s = 6'd0;
    for (int b = 0; b < 4; b++) begin
      if (b < k) s = s + v[6*b+:6];
    end
    return s;
  endfunction
  // Element count and source slots per format
  function automatic logic [10:0] fmap(input logic [3:0] f);
    unique case (f)
      F_RED, F_DEPTH, F_STENCIL: return {3'd1, 8'h00};
      F_GREEN: return {3'd1, 8'h01};
      F_BLUE:  return {3'd1, 8'h02};
      F_ALPHA: return {3'd1, 8'h03};
      F_RG, F_DS: return {3'd2, 8'h04};
      F_RGB:   return {3'd3, 8'h24};
      F_BGR:   return {3'd3, 8'h06};
      F_RGBA:  return {3'd4, 8'he4};
      F_BGRA:  return {3'd4, 8'hc6};
      default: return 11'h0;
    endcase
  endfunction
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  prc_state_t        st_q;
  logic [1:0]        clamp_q;
  logic              rev_q;
  logic [4:0]        type_q;
  logic [3:0]        fmt_q;
  logic [31:0]       dest_q;
  logic [31:0]       bind_q;
  logic [31:0]       bsz_q;
  logic [15:0]       wid_q;
  logic [15:0]       hgt_q;
  logic [15:0]       rowl_q;
  logic [3:0]        align_q;
  logic [15:0]       skpx_q;
  logic [15:0]       skrw_q;
  logic [1:0]        stat_q;
  logic [1:0]        mask_q;
  logic              go_q;
  logic              bvalid_q;
  logic              rvalid_q;
  logic [1:0]        bresp_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [3:0][31:0]  wd_q;
  logic [2:0]        nl_q;
  logic [31:0]       addr_q;
  logic              lastg_q;
  logic              allin_q;
  logic              buf_q;
  logic [15:0]       i_q;
  logic [15:0]       j_q;
  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  logic [31:0] ctrl_v;
  logic [31:0] stat_v;
  logic [31:0] wview;
  logic [31:0] wm;
  logic [31:0] rmux;
  logic        wr_go;
  logic        rd_go;
  logic        w_hit;
  logic        r_hit;
  logic        clr_ok;
  logic [1:0]  ev_st;
  assign ctrl_v = {19'h0, fmt_q, type_q, 1'b0, rev_q, clamp_q};
  assign stat_v = {29'h0, st_q == S_RUN, stat_q};
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_go = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  function automatic logic [32:0] rdsel(input logic [7:0] a, input logic [31:0] c,
                                        input logic [31:0] d, input logic [31:0] b,
                                        input logic [31:0] z, input logic [31:0] s,
                                        input logic [31:0] r, input logic [31:0] k,
                                        input logic [31:0] t, input logic [31:0] m);
    unique case (a)
      OFF_CTRL: return {1'b1, c};
      OFF_DEST: return {1'b1, d};
      OFF_BIND: return {1'b1, b};
      OFF_BSZ:  return {1'b1, z};
      OFF_SIZE: return {1'b1, s};
      OFF_ROW:  return {1'b1, r};
      OFF_SKIP: return {1'b1, k};
      OFF_STAT: return {1'b1, t};
      OFF_MASK: return {1'b1, m};
      default:  return 33'h0;
    endcase
  endfunction
  logic [31:0] size_v;
  logic [31:0] row_v;
  logic [31:0] skip_v;
  assign size_v = {hgt_q, wid_q};
  assign row_v  = {12'h0, align_q, rowl_q};
  assign skip_v = {skrw_q, skpx_q};
  assign {w_hit, wview} = rdsel(s_axi_awaddr, ctrl_v, dest_q, bind_q, bsz_q, size_v,
                                row_v, skip_v, stat_v, {30'h0, mask_q});
  assign {r_hit, rmux} = rdsel(s_axi_araddr, ctrl_v, dest_q, bind_q, bsz_q, size_v,
                               row_v, skip_v, stat_v, {30'h0, mask_q});
  assign wm = be(wview, s_axi_wdata, s_axi_wstrb);
  assign clr_ok = wr_go & (s_axi_awaddr == OFF_STAT) & s_axi_wstrb[0];
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;
  assign irq = |(stat_q & mask_q);
  // ----------------------------------------
  // Transfer geometry and checks
  // ----------------------------------------
  logic [5:0]  tw;
  logic [2:0]  tb;
  logic [23:0] fwv;
  logic        pk;
  logic [2:0]  nel;
  logic [7:0]  sel;
  logic [2:0]  nw;
  logic [5:0]  gb;
  logic [31:0] rowb;
  logic [31:0] stride;
  logic [31:0] gaddr;
  logic [47:0] endb;
  logic        bad;
  logic        empty;
  logic        lastg;
  logic        acc;
  logic        take;
  logic        fin;
  assign tw  = twid(type_q);
  assign tb  = tw[5:3];
  assign fwv = fwtab(type_q);
  assign pk  = fwv != 24'h0;
  assign {nel, sel} = fmap(fmt_q);
  assign nw  = pk ? 3'd1 : (type_q == T_FDS) ? 3'd2 : nel;
  assign gb  = 6'(nw * tb);
  assign rowb = 32'(((rowl_q != 16'h0) ? rowl_q : wid_q) * gb);
  assign stride = (rowb + 32'(align_q) - 32'h1) & ~(32'(align_q) - 32'h1);
  assign gaddr = dest_q + 32'((skrw_q + j_q) * stride) + 32'((skpx_q + i_q) * gb);
  assign endb = 48'(dest_q) + 48'((48'(skrw_q) + 48'(hgt_q) - 48'h1) * 48'(stride))
              + 48'((48'(skpx_q) + 48'(wid_q)) * 48'(gb));
  assign empty = (wid_q == 16'h0) | (hgt_q == 16'h0);
  assign bad = (tw == 6'd0) | (nel == 3'd0)
             | ((bind_q != 32'h0) & ((dest_q & 32'(tb - 3'd1)) != 32'h0))
             | ((bind_q != 32'h0) & ~empty & (endb > 48'(bsz_q)));
  assign lastg = (i_q == wid_q - 16'h1) & (j_q == hgt_q - 16'h1);
  assign mem_valid = nl_q != 3'd0;
  assign take = mem_valid & mem_ready;
  assign pix_ready = (st_q == S_RUN) & ~allin_q
                   & ((nl_q == 3'd0) | ((nl_q == 3'd1) & mem_ready));
  assign acc = pix_valid & pix_ready;
  assign fin = take & (nl_q == 3'd1) & lastg_q;
  assign ev_st[ST_DONE] = fin | (go_q & (st_q == S_IDLE) & ~bad & empty);
  assign ev_st[ST_ERR]  = go_q & (st_q == S_IDLE) & bad;
  assign mem_addr = addr_q;
  assign mem_data = wd_q[0];
  assign mem_size = tb;
  assign mem_to_buffer = buf_q;
  // ----------------------------------------
  // Per-slot conversion
  // ----------------------------------------
  logic [3:0][31:0] pc;
  logic [3:0][31:0] fc;
  logic [3:0][31:0] sec;
  logic [3:0][31:0] ev;
  logic [3:0][31:0] fld;
  logic [3:0][31:0] wd;
  logic [31:0]      mx01;
  logic [31:0]      mx;
  logic [4:0]       es0;
  logic [4:0]       es;
  logic             sgn;
  logic             half;
  logic             flt;
  logic             cl_en;
  logic             revp;
  assign pc = {pix_c3, pix_c2, pix_c1, pix_c0};
  assign sgn = (type_q == T_BYTE) | (type_q == T_SHORT) | (type_q == T_INT);
  assign half = type_q == T_HALF;
  assign flt = half | (type_q == T_FLOAT) | (type_q == T_FDS)
             | (type_q == T_SMALL_FLOAT_RGB) | (type_q == T_SHARED_EXP_RGB);
  assign cl_en = (clamp_q == CLAMP_TRUE)
               | ((clamp_q == CLAMP_FIXED_ONLY) & (pix_kind == K_FIXED));
  assign revp = rev_q | (type_q == T_SMALL_FLOAT_RGB) | (type_q == T_SHARED_EXP_RGB);
  // Shared exponent from the largest clamped component
  assign mx01 = (sec[0] > sec[1]) ? sec[0] : sec[1];
  assign mx   = (mx01 > sec[2]) ? mx01 : sec[2];
  assign es0  = (mx[30:23] >= 8'd111) ? 5'(mx[30:23] - 8'd111) : 5'd0;
  assign es   = (m9(mx, es0) == 10'd512) ? es0 + 5'd1 : es0;
  for (genvar k = 0; k < 4; k++) begin : g_slot
    logic [31:0] c;
    logic        idx;
    logic        ints;
    logic [5:0]  fw;
    logic [5:0]  iw;
    logic [32:0] fx;
    logic [65:0] pr;
    logic [14:0] mf;
    logic [31:0] fi;
    logic [5:0]  pos;
    assign c = pc[sel[2*k+:2]];
    assign idx = (pix_kind == K_INDEX) | ((pix_kind == K_DS) & (k == 1));
    assign ints = (pix_kind == K_SINT) | (pix_kind == K_UINT);
    assign fw = pk ? fwv[6*k+:6] : tw;
    assign iw = ((type_q == T_FDS) | (type_q == T_P248)) ? 6'd8 : sgn ? fw - 6'd1 : fw;
    // Depth-stencil components of float types are never clamped
    assign fc[k] = ((cl_en & (pix_kind != K_DS)) | ~flt) ? cl01(c) : c;
    assign sec[k] = fc[k][31] ? 32'h0 : (fc[k] > F_SE_MAX) ? F_SE_MAX : fc[k];
    assign fx = f2fx(fc[k]);
    assign pr = ({33'h0, fx} << fw) - {33'h0, fx};
    assign mf = minif(fc[k]);
    assign fi = i2f(c);
    assign ev[k] =
        (type_q == T_SHARED_EXP_RGB) ? ((k == 3) ? {27'h0, es}
                                     : {22'h0, m9(sec[k], es)}) :
        (type_q == T_SMALL_FLOAT_RGB) ? (fc[k][31] ? 32'h0
                                     : ({17'h0, mf} >> ((k == 2) ? 5 : 4))) :
        idx ? (half ? {17'h0, minif(fi)}
             : (type_q == T_FLOAT) ? fi
             : c & msk(iw)) :
        ints ? sat(c, fw, pix_kind == K_SINT, sgn) :
        half ? {16'h0, fc[k][31], mf} :
        flt ? fc[k] :
        sgn ? pr[64:33] : 32'((pr + 66'h8000_0000) >> 32);
    assign pos = revp ? psum(fwv, k) : psum(fwv, 4) - psum(fwv, k + 1);
    assign fld[k] = 32'({32'h0, ev[k] & msk(fw)} << pos);
    assign wd[k] = pk ? ((k == 0) ? (fld[0] | fld[1] | fld[2] | fld[3]) : 32'h0)
                      : ev[k] & msk(tw);
  end
  // ----------------------------------------
  // Register bus and status
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clamp_q <= CLAMP_RST;
      {rev_q, type_q, fmt_q, go_q, mask_q, stat_q} <= '0;
      {dest_q, bind_q, bsz_q, wid_q, hgt_q, rowl_q, skpx_q, skrw_q} <= '0;
      align_q <= ALIGN_RST;
      {bvalid_q, rvalid_q, bresp_q, rresp_q, rdata_q} <= '0;
    end else begin
      go_q <= wr_go & (s_axi_awaddr == OFF_CTRL) & wm[CTL_GO_BIT];
      bvalid_q <= wr_go | (bvalid_q & ~s_axi_bready);
      if (wr_go) bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
      rvalid_q <= rd_go | (rvalid_q & ~s_axi_rready);
      if (rd_go) begin
        rdata_q <= rmux;
        rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end
      stat_q <= (stat_q & ~(clr_ok ? s_axi_wdata[1:0] : 2'b00)) | ev_st;
      if (wr_go) begin
        unique case (s_axi_awaddr)
          OFF_CTRL: {fmt_q, type_q, rev_q, clamp_q} <= {wm[12:4], wm[2:0]};
          OFF_DEST: dest_q <= wm;
          OFF_BIND: bind_q <= wm;
          OFF_BSZ:  bsz_q <= wm;
          OFF_SIZE: {hgt_q, wid_q} <= wm;
          OFF_ROW: begin
            rowl_q <= wm[15:0];
            // Only alignments of 1, 2, 4 or 8 are kept
            if ($onehot(wm[19:16])) align_q <= wm[19:16];
          end
          OFF_SKIP: {skrw_q, skpx_q} <= wm;
          OFF_MASK: mask_q <= wm[1:0];
          default: ;
        endcase
      end
    end
  end
  // ----------------------------------------
  // Group sequencing and memory writes
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      {wd_q, nl_q, addr_q, lastg_q, allin_q, buf_q, i_q, j_q} <= '0;
    end else if (st_q == S_IDLE) begin
      if (go_q & ~bad & ~empty) begin
        st_q <= S_RUN;
        {i_q, j_q, allin_q} <= '0;
        buf_q <= bind_q != 32'h0;
      end
    end else begin
      if (acc) begin
        wd_q <= wd;
        nl_q <= nw;
        addr_q <= gaddr;
        lastg_q <= lastg;
        allin_q <= lastg;
        i_q <= (i_q == wid_q - 16'h1) ? 16'h0 : i_q + 16'h1;
        if (i_q == wid_q - 16'h1) j_q <= j_q + 16'h1;
      end else if (take) begin
        wd_q <= {32'h0, wd_q[3:1]};
        nl_q <= nl_q - 3'd1;
        addr_q <= addr_q + 32'(tb);
      end
      if (fin) st_q <= S_IDLE;
    end
  end
endmodule

/* File: sim/prc_converter_bench.sv */
// Purpose: Self-checking bench of the pack converter.
// Assumes: Memory model on the write side.
// Notes:   Expected words are worked out by hand per case.
`timescale 1ns/1ps
module prc_converter_bench import prc_pkg::*; ;
  typedef struct {prc_clamp_t c; logic [2:0] k; prc_type_t t; prc_fmt_t f;
                  logic [31:0] a, b, e;} prc_case_t;
  localparam logic [31:0] F_TWO = 32'h4000_0000;
  logic        clock = 1'b0, rst = 1'b1, slow = 1'b0, ir, s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, pix_valid = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_ready, mem_valid;
  logic        mem_ready, mem_to_buffer, irq;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, pix_c0 = 32'h0, pix_c1 = 32'h0, pix_c2 = 32'h0;
  logic [31:0] pix_c3 = 32'h0, s_axi_rdata, mem_addr, mem_data, st;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  pix_kind = 3'h0, mem_size;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          error_cnt = 0, comparisons = 0, b;
  prc_converter prc_converter_i (.*);
  prc_mem_model prc_mem_model_i (.*);
  always #2.5 clock = ~clock;
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    do @(posedge clock); while ((s_axi_awready & s_axi_wready) !== 1'b1);
    s_axi_awvalid <= 1'b0; s_axi_wvalid <= 1'b0;
    // Late bready so a held response is seen
    @(posedge clock); s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp; s_axi_bready <= 1'b0; @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; @(posedge clock);
  endtask
  task automatic cfg(input logic [31:0] d, bd, bs, sz, rw, sk);
    wr(OFF_DEST, d); wr(OFF_BIND, bd); wr(OFF_BSZ, bs);
    wr(OFF_SIZE, sz); wr(OFF_ROW, rw); wr(OFF_SKIP, sk);
  endtask
  task automatic go(input prc_case_t x, input int n);
    b = prc_mem_model_i.addr_q.size();
    wr(OFF_CTRL, {19'h0, x.f, x.t, 2'h2, x.c});
    repeat (n) begin
      pix_kind <= x.k; pix_c0 <= x.a; pix_c1 <= x.b; pix_c2 <= x.a; pix_c3 <= x.b;
      pix_valid <= 1'b1;
      do @(posedge clock); while (pix_ready !== 1'b1);
    end
    pix_valid <= 1'b0;
    do rd(OFF_STAT, st); while (st[ST_DONE] !== 1'b1 && st[ST_ERR] !== 1'b1);
    ir = irq;
    wr(OFF_STAT, 32'h3);
  endtask
  task automatic wchk(input int i, input logic [31:0] a, d, m);
    chk(prc_mem_model_i.addr_q[b+i], a);
    chk(prc_mem_model_i.data_q[b+i] & m, d);
  endtask
  task automatic t_reset;
    rd(OFF_CTRL, st);
    chk(32'(st[1:0]), 32'(CLAMP_FIXED_ONLY));
    rd(OFF_ROW, st);
    chk(32'(r), 32'(RESP_OKAY));
    chk(32'(st[19:16]), 32'h4);
    wr(8'h40, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(OFF_MASK, 32'h2);
  endtask
  task automatic t_table;
    prc_case_t cs[12] = '{
      '{CLAMP_FALSE, 3'h1, T_FLOAT, F_RED, F_TWO, 32'h0, F_TWO},
      '{CLAMP_TRUE, 3'h1, T_FLOAT, F_RED, F_TWO, 32'h0, F_ONE},
      '{CLAMP_FIXED_ONLY, 3'h1, T_FLOAT, F_RED, F_TWO, 32'h0, F_TWO},
      '{CLAMP_FIXED_ONLY, 3'h0, T_FLOAT, F_RED, F_TWO, 32'h0, F_ONE},
      '{CLAMP_FALSE, 3'h1, T_UBYTE, F_RED, F_TWO, 32'h0, 32'hff},
      '{CLAMP_FALSE, 3'h1, T_SHORT, F_GREEN, 32'h0, F_ONE, 32'h7fff},
      '{CLAMP_FALSE, 3'h4, T_BYTE, F_STENCIL, 32'hffff_ffff, 32'h0, 32'h7f},
      '{CLAMP_FALSE, 3'h4, T_FLOAT, F_STENCIL, 32'h3, 32'h0, 32'h4040_0000},
      '{CLAMP_FALSE, 3'h2, T_SHORT, F_RED, 32'hfffe_0000, 32'h0, 32'h8000},
      '{CLAMP_FALSE, 3'h1, T_P565, F_RGB, F_ONE, 32'h0, 32'hf81f},
      '{CLAMP_FALSE, 3'h1, T_SMALL_FLOAT_RGB, F_RGB, F_ONE, F_ONE, 32'h781e_03c0},
      '{CLAMP_FALSE, 3'h1, T_SHARED_EXP_RGB, F_RGB, F_ONE, F_ONE, 32'h8402_0100}};
    cfg(32'h40, 32'h0, 32'h0, 32'h0001_0001, 32'h0004_0000, 32'h0);
    foreach (cs[i]) begin
      go(cs[i], 1);
      chk(32'(prc_mem_model_i.addr_q.size() - b), 32'h1);
      wchk(0, 32'h40, cs[i].e, cs[i].t inside {T_BYTE, T_UBYTE} ? 32'hff :
        cs[i].t inside {T_SHORT, T_P565} ? 32'hffff :
        32'hffff_ffff);
    end
  endtask
  task automatic t_stream;
    prc_case_t x = '{CLAMP_FALSE, 3'h0, T_UBYTE, F_RGBA, F_ONE, 32'h0, 32'h0};
    slow <= 1'b1;
    // Row of 3 groups pads to 16 bytes under alignment 8
    cfg(32'h100, 32'h0, 32'h0, 32'h0002_0002, 32'h0008_0003, 32'h0001_0001);
    go(x, 4);
    for (int i = 0; i < 16; i++)
      wchk(i, 32'h114 + 32'((i / 8) * 16 + i % 8),
           (i % 2) ? 32'h0 : 32'hff, 32'hff);
    slow <= 1'b0;
  endtask
  task automatic t_buf;
    prc_case_t x = '{CLAMP_FALSE, 3'h1, T_USHORT, F_RED, F_ONE, 32'h0, 32'h0};
    cfg(32'h4, 32'h1, 32'h10, 32'h0001_0002, 32'h0004_0000, 32'h0);
    go(x, 2);
    wchk(0, 32'h4, 32'hffff, 32'hffff);
    wchk(1, 32'h6, 32'hffff, 32'hffff);
    chk(32'(mem_size), 32'h2);
    chk(32'(prc_mem_model_i.tob_q[b]), 32'h1);
    chk(32'(ir), 32'h0);
    wr(OFF_BSZ, 32'h4);
    go(x, 0);
    chk(32'(st[ST_ERR]), 32'h1);
    chk(32'(ir), 32'h1);
    chk(32'(irq), 32'h0);
    wr(OFF_BSZ, 32'h10);
    wr(OFF_DEST, 32'h1);
    go(x, 0);
    chk(32'(st[ST_ERR]), 32'h1);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset; t_table; t_stream; t_buf;
    final_report;
  end
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
endmodule

/* File: sim/prc_converter_monitor.sv */
// Purpose: Port checks of the pack converter.
// Assumes: One clock, rst async active high.
// Notes:   Bound into every converter instance.
`timescale 1ns/1ps
module prc_converter_monitor (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        pix_valid,
  input wire logic        pix_ready,
  input wire logic        mem_valid,
  input wire logic        mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_data,
  input wire logic [2:0]  mem_size,
  input wire logic        mem_to_buffer
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_mem_hold: assert property (mem_valid && !mem_ready |=> mem_valid &&
    $stable({mem_addr, mem_data, mem_size, mem_to_buffer})) else $error("word moved on stall");
  a_pix_answer: assert property (pix_valid && pix_ready |=> mem_valid)
    else $error("no word after group");
  a_stall_blocks: assert property (mem_valid && !mem_ready |-> !pix_ready)
    else $error("group taken during stall");
  a_size_legal: assert property (mem_valid |-> mem_size inside {3'h1, 3'h2, 3'h4})
    else $error("bad word size");
  a_buf_align: assert property (mem_valid && mem_to_buffer |->
    (mem_addr[2:0] & (mem_size - 3'h1)) == 3'h0) else $error("unaligned buffer word");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("response dropped");
  a_resp_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answering");
  c_buf_word: cover property (mem_valid && mem_ready && mem_to_buffer);
  c_stall: cover property (mem_valid && !mem_ready ##1 mem_valid && mem_ready);
  c_back: cover property (pix_valid && pix_ready ##1 pix_valid && pix_ready);
endmodule
bind prc_converter prc_converter_monitor prc_converter_monitor_i (.clock, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .pix_valid, .pix_ready, .mem_valid,
  .mem_ready, .mem_addr, .mem_data, .mem_size, .mem_to_buffer);

/* File: sim/prc_mem_model.sv */
// Purpose: Memory side that takes packed words.
// Assumes: One word per valid/ready handshake.
// Notes:   Slow mode takes one word in four cycles.
`timescale 1ns/1ps
module prc_mem_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic        mem_valid,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_data,
  input  wire logic        mem_to_buffer,
  output logic             mem_ready
);
  logic [31:0] addr_q[$], data_q[$];
  logic        tob_q[$];
  logic [1:0]  cnt_q = 2'h0;
  // Stalls in slow mode, so held words get exercised
  assign mem_ready = !slow || cnt_q == 2'h3;
  always @(posedge clock) begin
    cnt_q <= cnt_q + 2'h1;
    if (mem_valid && mem_ready) begin
      addr_q.push_back(mem_addr);
      data_q.push_back(mem_data);
      tob_q.push_back(mem_to_buffer);
    end
  end
endmodule
